// *** bench/external_bus_wait_state_control_test.sv ***
// Self-checking testbench for the wait-state unit.
`timescale 1ns/100ps
module external_bus_wait_state_control_test;
  import wsu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        bus_start, bus_ext_addr, bus_accept, bus_wait_state, bus_end;
  logic        wait_req_n, hw_standby, periph_tick, periph_halve, stretch;
  int          err_total, cmp_count;

  wsu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .bus_start(bus_start), .bus_ext_addr(bus_ext_addr),
    .bus_accept(bus_accept), .bus_wait_state(bus_wait_state), .bus_end(bus_end),
    .wait_req_n(wait_req_n), .hw_standby(hw_standby), .periph_tick(periph_tick),
    .periph_halve(periph_halve));

  wsu_slow_dev u_dev (.pclk(pclk), .presetn(presetn), .bus_start(bus_start),
    .bus_accept(bus_accept), .bus_ext_addr(bus_ext_addr), .bus_end(bus_end),
    .stretch(stretch), .wait_req_n(wait_req_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] r;
    logic        e;
    apb(1'b1, WSU_CTRL_OFFSET, {24'h000000, d}, s, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, exp_err}, "error flag");
  endtask

  // Counts wait states and checks the closing state lands 3 + waits cycles after the take.
  task automatic bus_run(input logic ext, output logic [31:0] waits);
    logic [31:0] cyc;
    waits = 32'h0;
    cyc   = 32'h0;
    @(posedge pclk);
    bus_start    <= 1'b1;
    bus_ext_addr <= ext;
    do @(negedge pclk); while (bus_accept !== 1'b1);
    @(posedge pclk);
    bus_start <= 1'b0;
    do begin
      @(negedge pclk);
      cyc = cyc + 32'h1;
      if (cyc == 32'h1) chk({31'h0, bus_accept}, 32'h0, "accept in first state");
      if (bus_wait_state === 1'b1) waits = waits + 32'h1;
    end while (bus_end !== 1'b1 && cyc < 32'd60);
    chk(cyc, waits + 32'h3, "cycle length");
  endtask

  task automatic test_reset;
    rd_chk(WSU_CTRL_OFFSET, {24'h0, WSU_CTRL_RESET}, 1'b0);
    chk({31'h0, periph_halve}, 32'h0, "halve after reset");
    $display("test_reset done");
  endtask

  task automatic test_reg;
    wr(8'hff);
    rd_chk(8'h00, 32'hff, 1'b0);
    wr(8'h00);
    rd_chk(8'h00, 32'hc0, 1'b0);
    wr(8'h10);
    rd_chk(8'h00, 32'hd0, 1'b0);
    wr(8'h2f, 4'h0);
    rd_chk(8'h00, 32'hd0, 1'b0);
    rd_chk(8'h04, 32'h0, 1'b1);
    $display("test_reg done");
  endtask

  task automatic test_clock;
    logic a;
    wr(8'h20);
    @(negedge pclk);
    a = periph_tick;
    @(negedge pclk);
    chk({31'h0, periph_halve}, 32'h1, "halve set");
    chk({31'h0, periph_tick}, {31'h0, ~a}, "tick alternates");
    @(negedge pclk);
    chk({31'h0, periph_tick}, {31'h0, a}, "tick alternates");
    wr(8'h00);
    repeat (3) @(negedge pclk);
    chk({31'h0, periph_tick}, 32'h1, "tick full rate");
    @(negedge pclk);
    chk({31'h0, periph_tick}, 32'h1, "tick full rate");
    $display("test_clock done");
  endtask

  task automatic test_modes;
    logic [31:0] w, exp;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        for (int s = 0; s < 2; s++) begin
          @(posedge pclk);
          stretch <= s[0];
          wr({4'h0, m[1:0], c[1:0]});
          bus_run(1'b1, w);
          exp = (m == 1 || (m == 3 && s == 0)) ? 32'h0 : 32'(c);
          if (m == 2 && s == 1) chk({31'h0, w > exp}, 32'h1, "pin extension");
          else chk(w, exp, "wait count");
        end
      end
    end
    bus_run(1'b0, w);
    chk(w, 32'h0, "internal cycle");
    stretch <= 1'b0;
    $display("test_modes done");
  endtask

  task automatic test_standby;
    wr(8'h17);
    rd_chk(8'h00, 32'hd7, 1'b0);
    @(posedge pclk);
    hw_standby <= 1'b1;
    repeat (4) @(posedge pclk);
    hw_standby <= 1'b0;
    rd_chk(8'h00, {24'h0, WSU_CTRL_RESET}, 1'b0);
    $display("test_standby done");
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // The full run needs a few hundred cycles; this limit only catches a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    complete_run();
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, bus_start, bus_ext_addr, hw_standby, stretch} = 7'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    pstrb  = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_reg();
    test_clock();
    test_modes();
    test_standby();
    complete_run();
  end
endmodule // external_bus_wait_state_control_test

// *** bench/wsu_slow_dev.sv ***
// Slow external device model that pulls the wait request low during its own accesses while stretch is high.
`timescale 1ns/100ps
module wsu_slow_dev (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Bus cycle view.
  input  wire logic bus_start,
  input  wire logic bus_accept,
  input  wire logic bus_ext_addr,
  input  wire logic bus_end,
  // Stretch accesses when high, answer promptly when low.
  input  wire logic stretch,
  // Wait request pin.
  output logic      wait_req_n
);
  logic [3:0] hold_q;

  // The chip select is active as soon as the external address is presented, which is
  // two clocks before the second bus state. That gives the pin synchroniser time to
  // settle before the wait decision. The pin has a pull-up, so it reads high otherwise.
  assign wait_req_n = ~((bus_start && bus_ext_addr && stretch) || (hold_q != 4'h0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 4'h0;
    end else if (bus_end) begin
      hold_q <= 4'h0;
    end else if (bus_start && bus_accept && bus_ext_addr && stretch) begin
      hold_q <= 4'h8;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
endmodule // wsu_slow_dev

// *** shared/wsu_pkg.sv ***
// Constants, types and helpers shared by the wait-state unit files.
package wsu_pkg;

  // Register map and layout of wait_and_clock_control.
  localparam logic [7:0] WSU_CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] WSU_CTRL_RESET     = 8'hc8;
  localparam logic [7:0] WSU_CTRL_FIXED_ONE = 8'hc0;
  localparam logic [7:0] WSU_CTRL_WR_MASK   = 8'h3f;
  localparam int         WSU_HALVE_BIT      = 5;
  localparam int         WSU_RSVD_BIT       = 4;
  localparam int         WSU_MODE_HI_BIT    = 3;
  localparam int         WSU_MODE_LO_BIT    = 2;
  localparam int         WSU_CNT_HI_BIT     = 1;
  localparam int         WSU_CNT_LO_BIT     = 0;
  localparam logic [1:0] WSU_CNT_ZERO       = 2'h0;

  // Wait mode field encoding.
  typedef enum logic [1:0] {
    WSU_MODE_PROG = 2'b00,
    WSU_MODE_NONE = 2'b01,
    WSU_MODE_PIN  = 2'b10,
    WSU_MODE_AUTO = 2'b11
  } wsu_mode_t;

  // Bus cycle states: idle, first, second, inserted wait and closing state.
  typedef enum logic [2:0] {
    WSU_ST_IDLE = 3'b000,
    WSU_ST_T1   = 3'b001,
    WSU_ST_T2   = 3'b010,
    WSU_ST_TW   = 3'b011,
    WSU_ST_T3   = 3'b100
  } wsu_state_t;

  // Read view of the control register; the two top bits always read as one.
  function automatic logic [31:0] wsu_read_word(input logic [7:0] ctrl);
    wsu_read_word = {24'h000000, ctrl | WSU_CTRL_FIXED_ONE};
  endfunction

  // Count decrement that holds at zero.
  function automatic logic [1:0] wsu_dec(input logic [1:0] cnt);
    wsu_dec = (cnt == WSU_CNT_ZERO) ? WSU_CNT_ZERO : cnt - 2'h1;
  endfunction

endpackage

// *** verilog/wsu_clk_div.sv ***
// Supporting-module clock tick: every cycle, or every second cycle when halved.
`timescale 1ns/100ps
module wsu_clk_div (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Control and tick out.
  input  wire logic halve,
  output logic      tick_q
);

  // A tick enable rather than a gated clock keeps one clock tree for the
  // supporting modules; they advance only on cycles where the tick is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b1;
    end else begin
      tick_q <= halve ? ~tick_q : 1'b1;
    end
  end

endmodule // wsu_clk_div

// *** verilog/wsu_sync2.sv ***
// Two-flop synchroniser for one level coming from a pin.
`timescale 1ns/100ps
module wsu_sync2 (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in and out.
  input  wire logic async_in,
  input  wire logic reset_level,
  output logic      sync_out
);

  logic meta_q;

  // The first flop feeds only the second one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in ^ reset_level;
      sync_out <= meta_q;
    end
  end

endmodule // wsu_sync2

// *** verilog/wsu_top.sv ***
// Wait-state unit: control register on APB, bus cycle wait insertion, clock halving.
// Function
// - Control register takes value c8 at reset and hardware standby, kept in software standby.
// - Top two control bits always read one; writes to them are dropped.
// - Bit 4 is a plain read/write storage bit clearing to zero at reset.
// - Mode field bits 3:2: programmable, none, pin wait, pin auto-wait.
// - Count field bits 1:0 selects zero to three wait states; reset picks zero.
// - Programmable mode inserts exactly the count on external cycles, ignoring wait request.
// - Pin mode inserts the count, plus further waits while wait request stays low in last.
// - Pin mode keeps adding waits while wait request stays low at each sample.
// - Auto-wait samples wait request in second state; inserts count only if low.
// - Auto-wait never adds waits beyond the selected count.
// - Bit 5 clear feeds supporting modules full clock; set feeds half clock.
`timescale 1ns/100ps
module wsu_top
  import wsu_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // CPU bus cycle request and state.
  input  wire logic        bus_start,
  input  wire logic        bus_ext_addr,
  output logic             bus_accept,
  output logic             bus_wait_state,
  output logic             bus_end,
  // Pins.
  input  wire logic        wait_req_n,
  input  wire logic        hw_standby,
  // Supporting-module clock.
  output logic             periph_tick,
  output logic             periph_halve
);

  // Register storage; the two top bits are not stored.
  logic [5:0]  ctrl_q;
  logic [5:0]  ctrl_d;
  logic [7:0]  ctrl_view;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  // Synchronised pins.
  logic        wait_low;
  logic        standby_s;

  // Bus cycle state.
  wsu_state_t  state_q;
  wsu_state_t  state_d;
  wsu_mode_t   mode_q;
  logic [1:0]  cnt_q;
  logic        ext_q;
  logic [1:0]  wcnt_q;
  logic [1:0]  wcnt_d;

  // APB decode.
  wire         apb_setup  = psel & ~penable;
  wire         apb_access = psel & penable;
  wire         addr_hit   = (paddr == WSU_CTRL_OFFSET);
  wire         wr_hit     = apb_access & pwrite & addr_hit & pstrb[0];

  // Field decode of the live register.
  wire         reg_halve  = ctrl_q[WSU_HALVE_BIT];
  wire [1:0]   reg_mode   = ctrl_q[WSU_MODE_HI_BIT:WSU_MODE_LO_BIT];
  wire [1:0]   reg_cnt    = ctrl_q[WSU_CNT_HI_BIT:WSU_CNT_LO_BIT];

  assign ctrl_view = {2'b11, ctrl_q};

  // Synchronise the wait request as an active-high "low seen" level, so that
  // the synchroniser resets to "no wait request".
  wsu_sync2 u_sync_wait (
    .pclk        (pclk),
    .presetn     (presetn),
    .async_in    (wait_req_n),
    .reset_level (1'b1),
    .sync_out    (wait_low)
  );

  wsu_sync2 u_sync_stby (
    .pclk        (pclk),
    .presetn     (presetn),
    .async_in    (hw_standby),
    .reset_level (1'b0),
    .sync_out    (standby_s)
  );

  // Only the writable bits take write data; bits 7 and 6 are dropped.
  assign ctrl_d = standby_s ? WSU_CTRL_RESET[5:0] :
                  wr_hit    ? (pwdata[5:0] & WSU_CTRL_WR_MASK[5:0]) :
                              ctrl_q;

  // Software standby has no input here at all, so the contents simply hold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= WSU_CTRL_RESET[5:0];
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Read data is loaded in the setup phase, so it is stable for the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q  <= addr_hit ? wsu_read_word(ctrl_view) : 32'h00000000;
      pslverr_q <= ~addr_hit;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & apb_access;

  // Supporting-module clock selection.
  assign periph_halve = reg_halve;

  wsu_clk_div u_clk_div (
    .pclk    (pclk),
    .presetn (presetn),
    .halve   (reg_halve),
    .tick_q  (periph_tick)
  );

  // Bus cycle sequencing. A new cycle is taken in idle or in the closing state.
  assign bus_accept     = (state_q == WSU_ST_IDLE) | (state_q == WSU_ST_T3);
  assign bus_wait_state = (state_q == WSU_ST_TW);
  assign bus_end        = (state_q == WSU_ST_T3);

  wire take_cycle = bus_start & bus_accept;

  // Waits only apply to external cycles in a mode that inserts them.
  wire ext_waits = ext_q & (mode_q != WSU_MODE_NONE);
  wire cnt_nz    = (cnt_q != WSU_CNT_ZERO);

  // Decision in the second state.
  logic t2_go_wait;
  logic [1:0] t2_wcnt;
  always_comb begin
    t2_go_wait = 1'b0;
    t2_wcnt    = WSU_CNT_ZERO;
    if (ext_waits) begin
      unique case (mode_q)
        WSU_MODE_PROG: begin
          t2_go_wait = cnt_nz;
          t2_wcnt    = wsu_dec(cnt_q);
        end
        WSU_MODE_PIN: begin
          t2_go_wait = cnt_nz | wait_low;
          t2_wcnt    = wsu_dec(cnt_q);
        end
        WSU_MODE_AUTO: begin
          t2_go_wait = cnt_nz & wait_low;
          t2_wcnt    = wsu_dec(cnt_q);
        end
        WSU_MODE_NONE: begin
          t2_go_wait = 1'b0;
          t2_wcnt    = WSU_CNT_ZERO;
        end
      endcase
    end
  end

  // Next state. In the last programmed wait only pin mode may extend.
  always_comb begin
    state_d = state_q;
    wcnt_d  = wcnt_q;
    unique case (state_q)
      WSU_ST_IDLE: begin
        if (take_cycle) begin
          state_d = WSU_ST_T1;
        end
      end
      WSU_ST_T1: begin
        state_d = WSU_ST_T2;
      end
      WSU_ST_T2: begin
        state_d = t2_go_wait ? WSU_ST_TW : WSU_ST_T3;
        wcnt_d  = t2_wcnt;
      end
      WSU_ST_TW: begin
        if (wcnt_q != WSU_CNT_ZERO) begin
          wcnt_d = wsu_dec(wcnt_q);
        end else if ((mode_q == WSU_MODE_PIN) && wait_low) begin
          state_d = WSU_ST_TW;
        end else begin
          state_d = WSU_ST_T3;
        end
      end
      WSU_ST_T3: begin
        state_d = take_cycle ? WSU_ST_T1 : WSU_ST_IDLE;
      end
      default: begin
        state_d = WSU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= WSU_ST_IDLE;
      wcnt_q  <= WSU_CNT_ZERO;
    end else begin
      state_q <= state_d;
      wcnt_q  <= wcnt_d;
    end
  end

  // Mode and count are caught when a cycle is taken, so a register write
  // during a cycle only affects the next one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= WSU_MODE_PIN;
      cnt_q  <= WSU_CNT_ZERO;
      ext_q  <= 1'b0;
    end else if (take_cycle) begin
      mode_q <= wsu_mode_t'(reg_mode);
      cnt_q  <= reg_cnt;
      ext_q  <= bus_ext_addr;
    end
  end

  // Checks on the behaviour above.

  property p_standby_reload;
    @(posedge pclk) disable iff (!presetn)
    standby_s |=> (ctrl_view == WSU_CTRL_RESET);
  endproperty
  a_standby_reload: assert property (p_standby_reload)
    else $error("Control register not reloaded during hardware standby.");

  property p_top_bits_one;
    @(posedge pclk) disable iff (!presetn)
    (apb_access && !pwrite && addr_hit) |-> (prdata[7:6] == 2'b11);
  endproperty
  a_top_bits_one: assert property (p_top_bits_one)
    else $error("Top control bits did not read as one.");

  property p_rsvd_bit_store;
    @(posedge pclk) disable iff (!presetn)
    (wr_hit && !standby_s) |=> (ctrl_q[WSU_RSVD_BIT] == $past(pwdata[WSU_RSVD_BIT]));
  endproperty
  a_rsvd_bit_store: assert property (p_rsvd_bit_store)
    else $error("Reserved storage bit did not keep written value.");

  property p_prog_three;
    @(posedge pclk) disable iff (!presetn)
    (state_q == WSU_ST_T2 && ext_q && mode_q == WSU_MODE_PROG && cnt_q == 2'h3)
      |=> bus_wait_state [*3] ##1 bus_end;
  endproperty
  a_prog_three: assert property (p_prog_three)
    else $error("Programmable mode did not insert exactly three waits.");

  property p_pin_extend;
    @(posedge pclk) disable iff (!presetn)
    (bus_wait_state && wcnt_q == WSU_CNT_ZERO && mode_q == WSU_MODE_PIN && wait_low)
      |=> bus_wait_state;
  endproperty
  a_pin_extend: assert property (p_pin_extend)
    else $error("Pin mode did not extend while wait request was low.");

  property p_pin_release;
    @(posedge pclk) disable iff (!presetn)
    (bus_wait_state && wcnt_q == WSU_CNT_ZERO && !wait_low) |=> bus_end;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("Wait state did not end after the last count.");

  property p_auto_skip;
    @(posedge pclk) disable iff (!presetn)
    (state_q == WSU_ST_T2 && mode_q == WSU_MODE_AUTO && !wait_low) |=> bus_end;
  endproperty
  a_auto_skip: assert property (p_auto_skip)
    else $error("Auto-wait inserted waits with wait request high.");

  property p_auto_limit;
    @(posedge pclk) disable iff (!presetn)
    (state_q == WSU_ST_T2 && ext_q && mode_q == WSU_MODE_AUTO && wait_low && cnt_q == 2'h2)
      |=> bus_wait_state [*2] ##1 bus_end;
  endproperty
  a_auto_limit: assert property (p_auto_limit)
    else $error("Auto-wait inserted a count other than the selected one.");

  property p_halve_tick;
    @(posedge pclk) disable iff (!presetn)
    (periph_halve && $past(periph_halve, 2)) |-> (periph_tick != $past(periph_tick));
  endproperty
  a_halve_tick: assert property (p_halve_tick)
    else $error("Halved supporting clock tick did not alternate.");

  property p_full_tick;
    @(posedge pclk) disable iff (!presetn)
    (!periph_halve && $past(!periph_halve)) |-> periph_tick;
  endproperty
  a_full_tick: assert property (p_full_tick)
    else $error("Undivided supporting clock tick missed a cycle.");

  property p_no_wait_cases;
    @(posedge pclk) disable iff (!presetn)
    (state_q == WSU_ST_T2 && (!ext_q || mode_q == WSU_MODE_NONE)) |=> bus_end;
  endproperty
  a_no_wait_cases: assert property (p_no_wait_cases)
    else $error("Waits inserted on an internal or no-wait cycle.");

endmodule // wsu_top
